/* File: inc/mic_if.sv */
interface mic_if (
  input wire logic pclk,
  input wire logic presetn
);
  logic        irq_req;     // Device to core: redirect request
  logic        irq_take;    // Core to device: redirection taken (pulse)
  logic        irq_return;  // Core to device: return instruction (pulse)
  logic [12:0] vector;      // Device to core: vector address
  logic        q1;          // Core to device: first quarter of cycle

  modport device (
    input  pclk,
    input  presetn,
    output irq_req,
    output vector,
    input  irq_take,
    input  irq_return,
    input  q1
  );

  modport core (
    input  pclk,
    input  presetn,
    input  irq_req,
    input  vector,
    output irq_take,
    output irq_return,
    output q1
  );
endinterface : mic_if

/* File: inc/mic_pkg.sv */
package mic_pkg;

  // ----------------------------------------------------------------
  // Register map (one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] MIC_OFS_CTRL   = 8'h00; // irq_control_reg
  localparam logic [7:0] MIC_OFS_ENABLE = 8'h04; // periph_enable_regs
  localparam logic [7:0] MIC_OFS_REQ5   = 8'h08; // periph_request_five
  localparam logic [7:0] MIC_OFS_STATUS = 8'h0C; // core status, read only

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MIC_BIT_GIE   = 7;  // global_irq_enable
  localparam int MIC_BIT_PERIPHERAL_GROUP_ENABLE  = 6;  // peripheral_group_enable
  localparam int MIC_BIT_T1G   = 0;  // timer1_gate_flag position
  localparam int MIC_BIT_CELL1 = 4;  // logic_cell1_flag, cells 2..4 above

  // Implemented bits of request register five
  localparam logic [7:0] MIC_REQ5_MASK = 8'hF1;

  // ----------------------------------------------------------------
  // Reset values, fixed vector and Q1 quarter value
  // ----------------------------------------------------------------
  localparam logic [7:0]  MIC_RST_CTRL   = 8'h00;
  localparam logic [7:0]  MIC_RST_ENABLE = 8'h00;
  localparam logic [7:0]  MIC_RST_REQ5   = 8'h00;
  localparam logic [12:0] MIC_VECTOR     = 13'h0004;
  localparam logic [1:0]  MIC_Q1         = 2'h0;

  // ----------------------------------------------------------------
  // Core-side states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MIC_RUN  = 2'b00,
    MIC_ISR  = 2'b01
  } mic_core_st_t;

endpackage : mic_pkg

/* File: verification/mic_check_sva.sv */
// ------------------------------
// Link checker
// ------------------------------
module mic_check_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        irq_req,
  input wire logic        irq_take,
  input wire logic        irq_return,
  input wire logic [12:0] vector,
  input wire logic        q1
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Vector never moves
  chk_vector_fixed:
    assert property (vector == mic_pkg::MIC_VECTOR) else $error("bad vector");
  // Software cannot enable within two cycles of release
  chk_reset_quiet:
    assert property ($rose(presetn) |-> !irq_req ##1 !irq_req)
    else $error("request after reset");
  chk_take_clears:
    assert property (irq_take |-> ##[1:2] !irq_req)
    else $error("global not cleared");
  chk_take_cause:
    assert property ($rose(irq_take) |-> $past(irq_req))
    else $error("take without request");
  chk_take_pulse:
    assert property (irq_take |=> !irq_take) else $error("take too long");
  chk_ret_pulse:
    assert property (irq_return |=> !irq_return) else $error("return long");
  chk_quarter_cycle:
    assert property (q1 |=> !q1 [*3] ##1 q1) else $error("q1 period");
  // Request is still low in the cycle of the return pulse
  chk_ret_quiet:
    assert property (irq_return |-> !irq_req) else $error("request in isr");
endmodule : mic_check_sva

/* File: verification/test_mcu_interrupt_control.sv */
module test_mcu_interrupt_control;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------
  // Stimulus and design
  // ------------------------------
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] e;
    logic        x;
  } mic_row_t;
  localparam mic_row_t rows [8] = '{
    '{mic_pkg::MIC_OFS_ENABLE, 32'hFF, 32'hF1, 1'b0},
    '{mic_pkg::MIC_OFS_REQ5, 32'hFF, 32'hF1, 1'b0},
    '{mic_pkg::MIC_OFS_REQ5, 32'h00, 32'h00, 1'b0},
    '{mic_pkg::MIC_OFS_CTRL, 32'hC0, 32'hC0, 1'b0},
    '{mic_pkg::MIC_OFS_CTRL, 32'h00, 32'h00, 1'b0},
    '{mic_pkg::MIC_OFS_ENABLE, 32'h00, 32'h00, 1'b0},
    '{mic_pkg::MIC_OFS_STATUS, 32'hFF, 32'h00, 1'b0},
    '{8'h10, 32'h05, 32'h00, 1'b1}};
  logic        pclk = 1'b0, presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, work_reg = 8'h5A, shadow_w;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, in_isr, e;
  logic [3:0]  logic_cell_event = 4'h0;
  logic        timer1_gate_event = 1'b0, return_instr = 1'b0;
  logic [12:0] pc, saved_pc;
  int          err_count = 0, checks = 0;
  mic_if mic_if_i (.pclk(pclk), .presetn(presetn));
  mic_ctrl mic_ctrl_i (.link(mic_if_i.device), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .logic_cell_event(logic_cell_event),
    .timer1_gate_event(timer1_gate_event));
  mic_core mic_core_i (.link(mic_if_i.core), .return_instr(return_instr),
    .pc(pc), .saved_pc(saved_pc), .shadow_w(shadow_w),
    .work_reg(work_reg), .in_isr(in_isr));
  mic_check_sva mic_check_sva_i (.pclk(pclk), .presetn(presetn),
    .irq_req(mic_if_i.irq_req), .irq_take(mic_if_i.irq_take),
    .irq_return(mic_if_i.irq_return), .vector(mic_if_i.vector),
    .q1(mic_if_i.q1));
  // ------------------------------
  // Tasks
  // ------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chk1
  // Response and read data are taken at the edge that sees pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    e = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rchk
  task automatic fire(input logic [3:0] c, input logic t);
    @(posedge pclk);
    logic_cell_event <= c;
    timer1_gate_event <= t;
    @(posedge pclk);
    logic_cell_event <= 4'h0;
    timer1_gate_event <= 1'b0;
  endtask : fire
  // Bounded wait; the longest redirect is under ten cycles
  task automatic wait_isr(input logic v);
    for (int i = 0; i < 40 && in_isr !== v; i++) @(posedge pclk);
    chk1(in_isr, v);
  endtask : wait_isr
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  // ------------------------------
  // Clock, watchdog, tests
  // ------------------------------
  initial forever #12.5 pclk = ~pclk;
  initial begin
    repeat (4000) @(posedge pclk);
    err_count++;
    end_sim();
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rchk(mic_pkg::MIC_OFS_CTRL, 32'h0);
    rchk(mic_pkg::MIC_OFS_REQ5, 32'h0);
    foreach (rows[k]) begin
      apb(1'b1, rows[k].a, rows[k].d);
      chk1(e, rows[k].x);
      rchk(rows[k].a, rows[k].e);
      chk1(e, rows[k].x);
    end
    $display("test registers done");
    apb(1'b1, mic_pkg::MIC_OFS_REQ5, 32'h0);
    apb(1'b1, mic_pkg::MIC_OFS_ENABLE, 32'hF1);
    fire(4'hF, 1'b1);
    rchk(mic_pkg::MIC_OFS_REQ5, 32'hF1);
    apb(1'b1, mic_pkg::MIC_OFS_CTRL, 32'h40);
    repeat (8) @(posedge pclk);
    chk1(in_isr, 1'b0);
    apb(1'b1, mic_pkg::MIC_OFS_CTRL, 32'h80);
    repeat (8) @(posedge pclk);
    chk1(in_isr, 1'b0);
    apb(1'b1, mic_pkg::MIC_OFS_CTRL, 32'hC0);
    wait_isr(1'b1);
    chk({19'h0, pc}, {19'h0, mic_pkg::MIC_VECTOR});
    chk({24'h0, shadow_w}, 32'h5A);
    rchk(mic_pkg::MIC_OFS_CTRL, 32'h40);
    rchk(mic_pkg::MIC_OFS_STATUS, 32'h2);
    apb(1'b1, mic_pkg::MIC_OFS_REQ5, 32'h0);
    fire(4'h2, 1'b0);
    rchk(mic_pkg::MIC_OFS_REQ5, 32'h20);
    chk1(mic_if_i.irq_req, 1'b0);
    return_instr <= 1'b1;
    wait_isr(1'b0);
    return_instr <= 1'b0;
    chk({19'h0, pc}, {19'h0, saved_pc});
    wait_isr(1'b1);
    apb(1'b1, mic_pkg::MIC_OFS_REQ5, 32'h0);
    return_instr <= 1'b1;
    wait_isr(1'b0);
    return_instr <= 1'b0;
    rchk(mic_pkg::MIC_OFS_CTRL, 32'hC0);
    $display("test service done");
    fire(4'h8, 1'b0);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rchk(mic_pkg::MIC_OFS_CTRL, 32'h0);
    chk1(in_isr, 1'b0);
    $display("test reset done");
    end_sim();
  end
endmodule : test_mcu_interrupt_control

/* File: verilog/mic_core.sv */
module mic_core (
  mic_if.core                link,
  input  wire logic          return_instr,
  output logic      [12:0]   pc,
  output logic      [12:0]   saved_pc,
  output logic      [7:0]    shadow_w,
  input  wire logic [7:0]    work_reg,
  output logic               in_isr
);

  // ----------------------------------------------------------------
  // State: quarter counter, program counter, one-deep stack, shadow
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]            quarter;
    logic [12:0]           pc;
    logic [12:0]           stack;
    logic [7:0]            shadow;
    mic_pkg::mic_core_st_t mode;
    logic                  take;
    logic                  ret;
  } mic_core_s_t;

  mic_core_s_t st_r;
  mic_core_s_t st_nxt;

  assign link.q1         = st_r.quarter == mic_pkg::MIC_Q1;
  assign link.irq_take   = st_r.take;
  assign link.irq_return = st_r.ret;
  assign pc       = st_r.pc;
  assign saved_pc = st_r.stack;
  assign shadow_w = st_r.shadow;
  assign in_isr   = st_r.mode == mic_pkg::MIC_ISR;

  // Instruction step advances PC each full cycle; redirect at cycle end
  always_comb begin
    st_nxt         = st_r;
    st_nxt.take    = 1'b0;
    st_nxt.ret     = 1'b0;
    st_nxt.quarter = st_r.quarter + 2'h1;
    unique case (st_r.mode)
      mic_pkg::MIC_RUN: begin
        if (st_r.quarter == 2'h3) begin
          if (link.irq_req) begin
            st_nxt.stack  = st_r.pc + 13'h0001;          // RQ5
            st_nxt.shadow = work_reg;                    // RQ5
            st_nxt.pc     = link.vector;                 // RQ5
            st_nxt.take   = 1'b1;
            st_nxt.mode   = mic_pkg::MIC_ISR;
          end else begin
            st_nxt.pc = st_r.pc + 13'h0001;
          end
        end
      end
      mic_pkg::MIC_ISR: begin
        if (st_r.quarter == 2'h3) begin
          if (return_instr) begin
            st_nxt.pc   = st_r.stack;                    // RQ7
            st_nxt.ret  = 1'b1;
            st_nxt.mode = mic_pkg::MIC_RUN;
          end else begin
            st_nxt.pc = st_r.pc + 13'h0001;
          end
        end
      end
      default: st_nxt.mode = mic_pkg::MIC_RUN;
    endcase
  end

  // Registers
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      st_r.quarter <= 2'h0;
      st_r.pc      <= 13'h0000;
      st_r.stack   <= 13'h0000;
      st_r.shadow  <= 8'h00;
      st_r.mode    <= mic_pkg::MIC_RUN;
      st_r.take    <= 1'b0;
      st_r.ret     <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule : mic_core

/* File: verilog/mic_ctrl.sv */
// Operation
// [RQ1] Any reset leaves all interrupts disabled
// [RQ2] Redirect needs global and individual enable
// [RQ3] Peripheral events also need group enable
// [RQ4] Flags set whatever the enables say
// [RQ5] Taking irq clears global, core vectors 0004h
// [RQ6] Flags still set while global clear
// [RQ7] Return instruction sets global enable again
// [RQ8] Enabled request pends until global set
// [RQ9] Requests sampled in first quarter-cycle
// [RQ10] Software clears serviced flags before return
// [RQ11] Software polls flags to find source
// [RQ12] Bits 7..4 cell flags, software clear
// [RQ13] Bits 3..1 read zero, bit0 gate
// [RQ14] Software clears flags before enabling
// [RQ15] Request is OR of gated enabled flags
//
// Chosen here: the register offsets and the APB slave port.
module mic_ctrl (
  mic_if.device              link,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic [3:0]    logic_cell_event,
  input  wire logic          timer1_gate_event
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  irq_control_reg;
    logic [7:0]  periph_enable_regs;
    logic [7:0]  periph_request_five;
    logic        req_sampled;
    logic [31:0] rdata;
    logic        in_service;
  } mic_dev_st_t;

  mic_dev_st_t st_r;
  mic_dev_st_t st_nxt;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Map check shared by the error flag and the read path
  function automatic logic mic_mapped(input logic [7:0] a);
    mic_mapped = a == mic_pkg::MIC_OFS_CTRL
              || a == mic_pkg::MIC_OFS_ENABLE
              || a == mic_pkg::MIC_OFS_REQ5
              || a == mic_pkg::MIC_OFS_STATUS;
  endfunction : mic_mapped

  // Read word for one offset; unmapped offsets read as zero
  function automatic logic [31:0] mic_read_word(
    input logic [7:0]  a,
    input mic_dev_st_t s,
    input logic        req
  );
    logic [31:0] word;
    word = 32'h0000_0000;
    if (mic_mapped(a)) begin
      unique case (a)
        mic_pkg::MIC_OFS_CTRL:
          word = {24'h000000, s.irq_control_reg};
        mic_pkg::MIC_OFS_ENABLE:
          word = {24'h000000, s.periph_enable_regs};
        mic_pkg::MIC_OFS_REQ5:   // RQ11
          word = {24'h000000, s.periph_request_five};
        mic_pkg::MIC_OFS_STATUS:
          word = {30'h0000_0000, s.in_service, req};
        default: word = 32'h0000_0000;
      endcase
    end
    mic_read_word = word;
  endfunction : mic_read_word

  logic wr_acc;
  logic rd_acc;
  logic addr_ok;
  logic pending;
  logic [7:0] events;

  // Zero-wait slave: every access completes in its first access cycle.
  // Read data is captured at the end of setup, so the registered word
  // already stands during the access cycle in which pready is high.
  assign wr_acc  = psel && penable && pwrite;
  assign rd_acc  = psel && !penable && !pwrite;
  assign addr_ok = mic_mapped(paddr);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata  = st_r.rdata;

  // Event lines mapped onto the flag layout
  assign events = {logic_cell_event, 3'h0, timer1_gate_event}; // RQ13

  // ----------------------------------------------------------------
  // Gated request
  // ----------------------------------------------------------------
  // Only peripheral sources exist here, so group gate always applies
  assign pending = |(st_r.periph_request_five
                     & st_r.periph_enable_regs
                     & mic_pkg::MIC_REQ5_MASK)                 // RQ15 RQ2
                && st_r.irq_control_reg[mic_pkg::MIC_BIT_PERIPHERAL_GROUP_ENABLE]; // RQ3

  // Global enable gates the core request; pending stays latched.
  // The live gate is rechecked too: a stale Q1 sample must not leak
  // through after software drops the group enable or a flag.
  assign link.irq_req = st_r.req_sampled && pending
                     && st_r.irq_control_reg[mic_pkg::MIC_BIT_GIE]; // RQ8
  assign link.vector  = mic_pkg::MIC_VECTOR;                   // RQ5

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt       = st_r;
    st_nxt.rdata = 32'h0000_0000;
    // Sample only in Q1 so latency depends on the running instruction
    if (link.q1) begin
      st_nxt.req_sampled = pending;                            // RQ9
    end
    // Software writes first; hardware set below wins a same-cycle clear
    if (wr_acc) begin
      unique case (paddr)
        mic_pkg::MIC_OFS_CTRL:   st_nxt.irq_control_reg = pwdata[7:0];
        mic_pkg::MIC_OFS_ENABLE: st_nxt.periph_enable_regs =
                                   pwdata[7:0] & mic_pkg::MIC_REQ5_MASK;
        mic_pkg::MIC_OFS_REQ5:   st_nxt.periph_request_five =
                                   pwdata[7:0] & mic_pkg::MIC_REQ5_MASK;
        default: ;
      endcase
    end
    // Capture in setup; the word stands only for the access cycle
    if (rd_acc) begin
      st_nxt.rdata = mic_read_word(paddr, st_r, link.irq_req);
    end
    // Flags set regardless of any enable; unused bits stay zero
    st_nxt.periph_request_five = st_nxt.periph_request_five
                               | (events & mic_pkg::MIC_REQ5_MASK); // RQ4 RQ6 RQ12
    // Taking the vector clears global enable, blocking nesting
    if (link.irq_take) begin
      st_nxt.irq_control_reg[mic_pkg::MIC_BIT_GIE] = 1'b0;    // RQ5
      st_nxt.in_service  = 1'b1;
      st_nxt.req_sampled = 1'b0;
    end else if (link.irq_return) begin
      st_nxt.irq_control_reg[mic_pkg::MIC_BIT_GIE] = 1'b1;    // RQ7
      st_nxt.in_service = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Usage notes
  // ----------------------------------------------------------------
  // Limitation: a flag that is still set when the return instruction
  // runs brings the core straight back to the vector, since the flag
  // is level state and nothing here remembers that it was serviced.
  // Software therefore clears serviced flags before it returns.
  //
  // Limitation: all sources share one vector, so the service routine
  // must read request register five to learn which cell or the timer
  // gate asked. Several flags may be set at once.
  //
  // Trade-off: the request is sampled once per instruction cycle, in
  // its first quarter. This adds up to a few cycles of latency but
  // keeps the Q1 sample, req_sampled, stable for a whole cycle.
  //
  // Hazard: enabling a source whose flag is already set fires at once.
  // Software clears stale flags before it writes the enable register.
  //
  // Status word: bit 1 shows service in progress, bit 0 the live core
  // request; both are read only and writes to that word are dropped.

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      st_r.irq_control_reg     <= mic_pkg::MIC_RST_CTRL;      // RQ1
      st_r.periph_enable_regs  <= mic_pkg::MIC_RST_ENABLE;    // RQ1
      st_r.periph_request_five <= mic_pkg::MIC_RST_REQ5;
      st_r.req_sampled         <= 1'b0;
      st_r.rdata               <= 32'h0000_0000;
      st_r.in_service          <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule : mic_ctrl
